// ### hdl/rtc_monitor_pkg.sv
// package for the rtc monitor and alarm interrupt block: offsets, fields, resets, timing
// assumes a 25 MHz ref_clk; time counters and prescaler live outside on the same clock
//
// Overview of operation
// RQ1 - supply-up reset restores both control registers
// RQ2 - halt flag sets on halt, write-0 clears
// RQ3 - power-on flag set also sets supply-low flag
// RQ4 - three monitor flags encode supply/oscillator condition
// RQ5 - bus locked from power-up until oscillation starts
// RQ6 - supply sampled only in 7.8 ms window per second
// RQ7 - supply-low set suspends sampling until written 0
// RQ8 - after power-up sampling waits for host clear
// RQ9 - low sample sets supply-low flag, stops sampling
// RQ10 - host clears supply-low once after writing seconds
// RQ11 - alarm pin low on weekly/daily time match
// RQ12 - weekly to pin B, daily to A; single-pin both
// RQ13 - periodic interrupt on pin A, pulse or level
// RQ14 - enables: weekly D7, daily D6, period D2..D0
// RQ15 - flags: periodic D2, weekly D1, daily D0
// RQ16 - with enables zero all interrupt pins stay high
// RQ17 - shared pin A is OR of active-low sources
// RQ18 - alarm enable one turns alarm on, zero off
// RQ19 - alarm flag write 1 ignored, 0 clears, releases pin
// RQ20 - clearing alarm flag keeps enable, rearms alarm
// RQ21 - host disables alarm while rewriting alarm time
// RQ22 - enabling on an existing match waits for next match
// RQ23 - period codes: off, low, 2Hz, 1Hz, level s/m/h/month
// RQ24 - level mode holds pin low until periodic flag cleared
// RQ25 - reads never alter flags; only written zeros clear

package rtc_monitor_pkg;

   localparam int unsigned CLK_FREQ_HZ          = 25_000_000;
   // supply sampling window, microseconds
   localparam int unsigned SAMPLE_WINDOW_US     = 7800;
   localparam int unsigned SAMPLE_WINDOW_CYCLES = (SAMPLE_WINDOW_US * (CLK_FREQ_HZ / 1_000_000));

   localparam logic [3:0] ADDR_ENABLE_CONTROL = 4'hE;
   localparam logic [3:0] ADDR_FLAG_STATUS    = 4'hF;

   // interrupt_enable_control fields
   localparam int unsigned BIT_WEEKLY_EN   = 7;
   localparam int unsigned BIT_DAILY_EN    = 6;
   localparam int unsigned BIT_PERIOD_MSB  = 2;

   // interrupt_flag_status fields
   localparam int unsigned BIT_SUPPLY_LOW  = 6;
   localparam int unsigned BIT_OSC_HALT    = 5;
   localparam int unsigned BIT_POWERON     = 4;
   localparam int unsigned BIT_PERIODIC    = 2;
   localparam int unsigned BIT_WEEKLY_FLAG = 1;
   localparam int unsigned BIT_DAILY_FLAG  = 0;

   localparam logic [7:0] RESET_ENABLE_CONTROL = 8'h00;
   localparam logic       RESET_MONITOR_FLAG   = 1'b1;
   localparam logic       RESET_IRQ_FLAG       = 1'b0;

   typedef enum logic [2:0] {
      PERIOD_OFF       = 3'h0,
      PERIOD_FIXED_LOW = 3'h1,
      PERIOD_PULSE_2HZ = 3'h2,
      PERIOD_PULSE_1HZ = 3'h3,
      PERIOD_LVL_SEC   = 3'h4,
      PERIOD_LVL_MIN   = 3'h5,
      PERIOD_LVL_HOUR  = 3'h6,
      PERIOD_LVL_MONTH = 3'h7
   } period_sel_type;

   typedef struct packed {
      logic           weeklyAlarmEnable;
      logic           dailyAlarmEnable;
      logic [2:0]     unused;
      period_sel_type periodSelect;
   } enable_ctrl_type;

   typedef struct packed {
      logic [2:0] dayOfWeek;
      logic [7:0] hour;
      logic [7:0] minute;
   } clock_time_type;

   typedef struct packed {
      logic secondTick;
      logic minuteTick;
      logic hourTick;
      logic monthTick;
      logic wave1Hz;
      logic wave2Hz;
   } time_events_type;

   typedef struct packed {
      logic [3:0] addr;
      logic       write;
      logic       read;
      logic [7:0] writeData;
   } reg_access_type;

endpackage

// ### hdl/alarm_matcher.sv
// one alarm comparator: flags a fresh time match while enabled
// assumes time and alarm values are on ref_clk, stable between counter updates
`timescale 1ns/1ps
`default_nettype none

module alarm_matcher
(
   input  wire logic                           ref_clk,
   input  wire logic                           resetn,
   input  wire logic                           useDay,
   input  wire logic                           enable,
   input  wire rtc_monitor_pkg::clock_time_type timeNow,
   input  wire rtc_monitor_pkg::clock_time_type alarmTime,
   output logic                                matchEvent
);
   import rtc_monitor_pkg::*;

   logic match;
   logic matchSeen_q;

   assign match = (timeNow.hour == alarmTime.hour) && (timeNow.minute == alarmTime.minute)
                  && (!useDay || (timeNow.dayOfWeek == alarmTime.dayOfWeek)); // RQ11

   // tracked even while disabled, so enabling on a standing match stays quiet
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         matchSeen_q <= 1'b1;
      else
         matchSeen_q <= match;
   end

   assign matchEvent = enable && match && !matchSeen_q; // RQ18 RQ22

endmodule // alarm_matcher

`default_nettype wire

// ### hdl/rtc_monitor.sv
// status monitor flags, alarm comparators and periodic interrupt with two control registers
// assumes resetn is the power-on reset from 0 V, and time counters drive events on ref_clk
`timescale 1ns/1ps
`default_nettype none

module rtc_monitor
#(
   parameter int unsigned SAMPLE_WINDOW_LEN = rtc_monitor_pkg::SAMPLE_WINDOW_CYCLES,
   parameter bit          SINGLE_PIN        = 1'b0
)
(
   input  wire logic                            ref_clk,
   input  wire logic                            resetn,
   input  wire rtc_monitor_pkg::reg_access_type regAccess,
   output logic [7:0]                           regReadData,
   output logic                                 busReady,
   input  wire logic                            oscRunningPin,
   input  wire logic                            supplyBelowPin,
   output logic                                 supplySampleEnable,
   input  wire rtc_monitor_pkg::time_events_type timeEvents,
   input  wire rtc_monitor_pkg::clock_time_type timeNow,
   input  wire rtc_monitor_pkg::clock_time_type weeklyAlarmTime,
   input  wire rtc_monitor_pkg::clock_time_type dailyAlarmTime,
   output logic                                 irqOutA_n,
   output logic                                 irqOutAOe,
   output logic                                 irqOutB_n,
   output logic                                 irqOutBOe,
   output logic                                 irqOutSingle_n,
   output logic                                 irqOutSingleOe
);
   import rtc_monitor_pkg::*;

   logic [31:0]     windowCount_q;
   logic            windowActive_q;
   logic            oscSync1_q;
   logic            oscSync2_q;
   logic            supplySync1_q;
   logic            supplySync2_q;
   logic            porActive_q;
   enable_ctrl_type enableCtrl_q;
   logic            poweronFlag_q;
   logic            oscHaltFlag_q;
   logic            supplyLowFlag_q;
   logic            periodicFlag_q;
   logic            weeklyFlag_q;
   logic            dailyFlag_q;
   logic [7:0]      readData_q;
   logic            writeEnable;
   logic            writeCtrl;
   logic            writeFlags;
   logic            clearSupplyLow;
   logic            lowSample;
   logic            weeklyMatch;
   logic            dailyMatch;
   logic            periodicEvent;
   logic            periodicLow;
   logic            weeklyLow;
   logic            dailyLow;
   logic            pinALow;
   logic            pinBLow;
   logic            pinSingleLow;
   logic [7:0]      flagView;

   // both pins are outside the clock domain; second stage only feeds logic
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         oscSync1_q    <= 1'b0;
         oscSync2_q    <= 1'b0;
         supplySync1_q <= 1'b0;
         supplySync2_q <= 1'b0;
      end
      else
      begin
         oscSync1_q    <= oscRunningPin;
         oscSync2_q    <= oscSync1_q;
         supplySync1_q <= supplyBelowPin;
         supplySync2_q <= supplySync1_q;
      end
   end

   // bus stays locked from power-up until the oscillator is seen running
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         porActive_q <= 1'b1;
      else if (oscSync2_q)
         porActive_q <= 1'b0; // RQ5
   end

   assign busReady    = !porActive_q;
   assign writeEnable = regAccess.write && !porActive_q; // RQ5
   assign writeCtrl   = writeEnable && (regAccess.addr == ADDR_ENABLE_CONTROL);
   assign writeFlags  = writeEnable && (regAccess.addr == ADDR_FLAG_STATUS);

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         enableCtrl_q <= enable_ctrl_type'(RESET_ENABLE_CONTROL); // RQ1
      else if (writeCtrl)
      begin
         enableCtrl_q.weeklyAlarmEnable <= regAccess.writeData[BIT_WEEKLY_EN]; // RQ14
         enableCtrl_q.dailyAlarmEnable  <= regAccess.writeData[BIT_DAILY_EN]; // RQ14
         enableCtrl_q.unused            <= 3'h0;
         enableCtrl_q.periodSelect      <= period_sel_type'(regAccess.writeData[BIT_PERIOD_MSB:0]); // RQ14
      end
   end

   // monitor flags come up set after a supply start from 0 V, giving code 111
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         poweronFlag_q <= RESET_MONITOR_FLAG; // RQ4
      else if (writeFlags && !regAccess.writeData[BIT_POWERON])
         poweronFlag_q <= 1'b0; // RQ25
   end

   // set wins over a same-cycle clear; a written one never sets
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         oscHaltFlag_q <= RESET_MONITOR_FLAG; // RQ4
      else if (!oscSync2_q)
         oscHaltFlag_q <= 1'b1; // RQ2
      else if (writeFlags && !regAccess.writeData[BIT_OSC_HALT])
         oscHaltFlag_q <= 1'b0; // RQ2
   end

   // sampling window: opens on each second tick, lasts the window length
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         windowCount_q  <= 32'h0;
         windowActive_q <= 1'b0;
      end
      else if (timeEvents.secondTick)
      begin
         windowCount_q  <= 32'h0;
         windowActive_q <= 1'b1; // RQ6
      end
      else if (windowActive_q)
      begin
         windowCount_q <= windowCount_q + 32'h1;
         if (windowCount_q == 32'(SAMPLE_WINDOW_LEN - 1))
            windowActive_q <= 1'b0; // RQ6
      end
   end

   // comparator is powered only in the window and only while the flag is clear
   assign supplySampleEnable = windowActive_q && !supplyLowFlag_q; // RQ6 RQ7 RQ8
   // comparator result is trusted only from the cycle after the window opens
   assign lowSample          = supplySampleEnable && supplySync2_q && (windowCount_q != 32'h0); // RQ9
   assign clearSupplyLow     = writeFlags && !regAccess.writeData[BIT_SUPPLY_LOW];

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         supplyLowFlag_q <= RESET_MONITOR_FLAG; // RQ3 RQ8
      else if (lowSample)
         supplyLowFlag_q <= 1'b1; // RQ9
      else if (clearSupplyLow)
         supplyLowFlag_q <= 1'b0; // RQ7
   end

   alarm_matcher weeklyMatcher
   (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .useDay     (1'b1),
      .enable     (enableCtrl_q.weeklyAlarmEnable),
      .timeNow    (timeNow),
      .alarmTime  (weeklyAlarmTime),
      .matchEvent (weeklyMatch)
   );

   alarm_matcher dailyMatcher
   (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .useDay     (1'b0),
      .enable     (enableCtrl_q.dailyAlarmEnable),
      .timeNow    (timeNow),
      .alarmTime  (dailyAlarmTime),
      .matchEvent (dailyMatch)
   );

   // alarm flags: clearing leaves the enable alone so the next match fires again
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         weeklyFlag_q <= RESET_IRQ_FLAG;
      else if (weeklyMatch)
         weeklyFlag_q <= 1'b1; // RQ11 RQ20
      else if (writeFlags && !regAccess.writeData[BIT_WEEKLY_FLAG])
         weeklyFlag_q <= 1'b0; // RQ19
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         dailyFlag_q <= RESET_IRQ_FLAG;
      else if (dailyMatch)
         dailyFlag_q <= 1'b1; // RQ11 RQ20
      else if (writeFlags && !regAccess.writeData[BIT_DAILY_FLAG])
         dailyFlag_q <= 1'b0; // RQ19
   end

   // periodic event per select code; pulse modes set the flag on each second tick too
   always_comb
   begin
      periodicEvent = 1'b0;
      unique case (enableCtrl_q.periodSelect)
         PERIOD_OFF,
         PERIOD_FIXED_LOW : periodicEvent = 1'b0;
         PERIOD_PULSE_2HZ,
         PERIOD_PULSE_1HZ,
         PERIOD_LVL_SEC   : periodicEvent = timeEvents.secondTick; // RQ23
         PERIOD_LVL_MIN   : periodicEvent = timeEvents.minuteTick; // RQ23
         PERIOD_LVL_HOUR  : periodicEvent = timeEvents.hourTick; // RQ23
         PERIOD_LVL_MONTH : periodicEvent = timeEvents.monthTick; // RQ23
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         periodicFlag_q <= RESET_IRQ_FLAG;
      else if (periodicEvent)
         periodicFlag_q <= 1'b1; // RQ15
      else if (writeFlags && !regAccess.writeData[BIT_PERIODIC])
         periodicFlag_q <= 1'b0; // RQ24
   end

   // pulse modes follow the prescaler wave low phase; level modes follow the flag
   always_comb
   begin
      periodicLow = 1'b0;
      unique case (enableCtrl_q.periodSelect)
         PERIOD_OFF       : periodicLow = 1'b0; // RQ16
         PERIOD_FIXED_LOW : periodicLow = 1'b1; // RQ23
         PERIOD_PULSE_2HZ : periodicLow = !timeEvents.wave2Hz; // RQ13
         PERIOD_PULSE_1HZ : periodicLow = !timeEvents.wave1Hz; // RQ13
         PERIOD_LVL_SEC,
         PERIOD_LVL_MIN,
         PERIOD_LVL_HOUR,
         PERIOD_LVL_MONTH : periodicLow = periodicFlag_q; // RQ24
      endcase
   end

   // a disabled alarm lets go of its pin even if its flag is still set
   assign weeklyLow    = weeklyFlag_q && enableCtrl_q.weeklyAlarmEnable; // RQ18
   assign dailyLow     = dailyFlag_q && enableCtrl_q.dailyAlarmEnable; // RQ18
   assign pinALow      = !SINGLE_PIN && (dailyLow || periodicLow); // RQ12 RQ17
   assign pinBLow      = !SINGLE_PIN && weeklyLow; // RQ12
   assign pinSingleLow = SINGLE_PIN && (weeklyLow || dailyLow || periodicLow); // RQ12 RQ17

   // open-drain pins: only ever pull low, enable marks the pull
   assign irqOutA_n      = 1'b0;
   assign irqOutAOe      = pinALow;
   assign irqOutB_n      = 1'b0;
   assign irqOutBOe      = pinBLow;
   assign irqOutSingle_n = 1'b0;
   assign irqOutSingleOe = pinSingleLow;

   always_comb
   begin
      flagView                  = 8'h00;
      flagView[BIT_SUPPLY_LOW]  = supplyLowFlag_q;
      flagView[BIT_OSC_HALT]    = oscHaltFlag_q;
      flagView[BIT_POWERON]     = poweronFlag_q;
      flagView[BIT_PERIODIC]    = periodicFlag_q;
      flagView[BIT_WEEKLY_FLAG] = weeklyFlag_q;
      flagView[BIT_DAILY_FLAG]  = dailyFlag_q;
   end

   // read data lands one cycle after the strobe; reads touch no flag
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         readData_q <= 8'h00;
      else if (regAccess.read && !porActive_q)
      begin
         if (regAccess.addr == ADDR_ENABLE_CONTROL)
            readData_q <= enableCtrl_q;
         else if (regAccess.addr == ADDR_FLAG_STATUS)
            readData_q <= flagView; // RQ25
         else
            readData_q <= 8'h00;
      end
   end

   assign regReadData = readData_q;

endmodule // rtc_monitor

`default_nettype wire

// ### verif/rtc_monitor_asserts.sv
// checker for the monitor and alarm interrupt block
// assumes it is bound onto rtc_monitor and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module rtc_monitor_asserts
#(
   parameter int unsigned SAMPLE_WINDOW_LEN = rtc_monitor_pkg::SAMPLE_WINDOW_CYCLES,
   parameter bit          SINGLE_PIN        = 1'b0
)
(
   input wire logic                             ref_clk,
   input wire logic                             resetn,
   input wire rtc_monitor_pkg::reg_access_type  regAccess,
   input wire logic                             busReady,
   input wire logic                             oscRunningPin,
   input wire logic                             supplyBelowPin,
   input wire logic                             supplySampleEnable,
   input wire rtc_monitor_pkg::time_events_type timeEvents,
   input wire rtc_monitor_pkg::clock_time_type  timeNow,
   input wire rtc_monitor_pkg::clock_time_type  weeklyAlarmTime,
   input wire logic                             irqOutAOe,
   input wire logic                             irqOutBOe,
   input wire logic                             irqOutSingleOe
);
   import rtc_monitor_pkg::*;
   int unsigned winCnt_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // length of the open window, zeroed between windows
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         winCnt_q <= 0;
      else if (supplySampleEnable)
         winCnt_q <= winCnt_q + 1;
      else
         winCnt_q <= 0;
   end
   // pulse-mode waves excused: the pin may follow them
   property pinHolds;
      irqOutAOe && !regAccess.write && $stable(timeEvents[1:0]) ##1 $stable(timeEvents[1:0]) |-> irqOutAOe;
   endproperty
   a_pins_idle_reset: assert property ($rose(resetn) |-> !irqOutAOe && !irqOutBOe && !irqOutSingleOe)
      else $error("interrupt pin pulled after reset");
   // two sync stages plus the lock flop: the pin was high three edges back
   a_bus_after_osc: assert property ($rose(busReady) |-> $past(oscRunningPin, 3))
      else $error("bus opened without oscillator");
   a_fixed_low_pin: assert property (!SINGLE_PIN && busReady && regAccess.write &&
      regAccess.addr == ADDR_ENABLE_CONTROL && regAccess.writeData[2:0] == 3'h1 |=> irqOutAOe)
      else $error("fixed low code left pin A free");
   a_window_opens: assert property ($rose(supplySampleEnable) |->
      $past(timeEvents.secondTick) || $past(regAccess.write))
      else $error("sampling started without a second tick");
   a_window_length: assert property (winCnt_q <= SAMPLE_WINDOW_LEN)
      else $error("sampling window too long");
   a_low_sample_stops: assert property ((supplySampleEnable && supplyBelowPin) [*2] |->
      ##[1:4] !supplySampleEnable)
      else $error("sampling kept on after low supply");
   a_weekly_pin_cause: assert property (!SINGLE_PIN && $rose(irqOutBOe) |->
      $past(timeNow == weeklyAlarmTime) || $past(regAccess.write))
      else $error("pin B pulled without weekly match");
   a_level_pin_holds: assert property (pinHolds)
      else $error("pin A released without a write");
   c_weekly_pin: cover property ($rose(irqOutBOe));
   c_window_done: cover property ($fell(supplySampleEnable));
   c_pin_a_freed: cover property ($fell(irqOutAOe));
endmodule // rtc_monitor_asserts
bind rtc_monitor rtc_monitor_asserts #(.SAMPLE_WINDOW_LEN(SAMPLE_WINDOW_LEN), .SINGLE_PIN(SINGLE_PIN)) chk_u
(
   .ref_clk(ref_clk), .resetn(resetn), .regAccess(regAccess), .busReady(busReady),
   .oscRunningPin(oscRunningPin), .supplyBelowPin(supplyBelowPin),
   .supplySampleEnable(supplySampleEnable), .timeEvents(timeEvents), .timeNow(timeNow),
   .weeklyAlarmTime(weeklyAlarmTime), .irqOutAOe(irqOutAOe), .irqOutBOe(irqOutBOe),
   .irqOutSingleOe(irqOutSingleOe)
);
`default_nettype wire

// ### verif/rtc_host_model.sv
// host model: strobe-per-access master on the register port
// assumes strobes are taken on the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
(
   input  wire logic                           ref_clk,
   input  wire logic                           busReady,
   input  wire logic [7:0]                     regReadData,
   output var rtc_monitor_pkg::reg_access_type regAccess
);
   import rtc_monitor_pkg::*;
   initial
   begin
      regAccess = '0;
   end
   task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      // no access until the oscillator runs; bounded wait
      while (busReady !== 1'b1 && n < 400)
      begin
         @(posedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      regAccess <= '{addr: a, write: w, read: !w, writeData: d};
      @(posedge ref_clk);
      regAccess <= '0;
      #1;
      q = regReadData;
   endtask
endmodule // rtc_host_model
`default_nettype wire

// ### verif/test_rtc_monitor_and_alarm_interrupts.sv
// bench for the monitor and alarm interrupt block
// assumes the host model on the register port; time inputs driven here
`timescale 1ns/1ps
`default_nettype none
module test_rtc_monitor_and_alarm_interrupts;
   import rtc_monitor_pkg::*;
   localparam int unsigned LEN = 20;
   localparam logic [3:0] E = ADDR_ENABLE_CONTROL;
   localparam logic [3:0] F = ADDR_FLAG_STATUS;
   logic            ref_clk;
   logic            resetn;
   reg_access_type  regAccess;
   logic [7:0]      rdData;
   logic            busReady;
   logic            oscRun;
   logic            supplyBelow;
   logic            sampleEn;
   time_events_type ev;
   clock_time_type  timeNow;
   clock_time_type  wkTime;
   clock_time_type  dyTime;
   logic            aOe;
   logic            bOe;
   logic            sOe;
   logic            aN;
   logic            bN;
   logic            sN;
   logic            oneA;
   logic            oneB;
   logic            oneOe;
   logic [7:0]      q;
   int              nFail;
   int              numChecks;
   int              cycles;
   rtc_monitor #(.SAMPLE_WINDOW_LEN(LEN), .SINGLE_PIN(1'b0)) dut_u
   (
      .ref_clk(ref_clk), .resetn(resetn), .regAccess(regAccess), .regReadData(rdData),
      .busReady(busReady), .oscRunningPin(oscRun), .supplyBelowPin(supplyBelow),
      .supplySampleEnable(sampleEn), .timeEvents(ev), .timeNow(timeNow),
      .weeklyAlarmTime(wkTime), .dailyAlarmTime(dyTime), .irqOutA_n(aN), .irqOutAOe(aOe),
      .irqOutB_n(bN), .irqOutBOe(bOe), .irqOutSingle_n(sN), .irqOutSingleOe(sOe)
   );
   // single-pin variant on the same inputs, so both share every scenario
   rtc_monitor #(.SAMPLE_WINDOW_LEN(LEN), .SINGLE_PIN(1'b1)) dutSingle_u
   (
      .ref_clk(ref_clk), .resetn(resetn), .regAccess(regAccess), .regReadData(),
      .busReady(), .oscRunningPin(oscRun), .supplyBelowPin(supplyBelow),
      .supplySampleEnable(), .timeEvents(ev), .timeNow(timeNow),
      .weeklyAlarmTime(wkTime), .dailyAlarmTime(dyTime), .irqOutA_n(), .irqOutAOe(oneA),
      .irqOutB_n(), .irqOutBOe(oneB), .irqOutSingle_n(), .irqOutSingleOe(oneOe)
   );
   rtc_host_model host_u
   (
      .ref_clk(ref_clk), .busReady(busReady), .regReadData(rdData), .regAccess(regAccess)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         nFail++;
         closeOut();
      end
   end
   task automatic closeOut();
      if (nFail == 0 && numChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         nFail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host_u.xfer(a, 1'b1, d, q);
   endtask
   task automatic rdChk(input string w, input logic [3:0] a, input logic [7:0] e);
      host_u.xfer(a, 1'b0, 8'h00, q);
      check(w, q, e);
   endtask
   // one-cycle tick on a timeEvents bit; bit 5 is the second tick
   task automatic pulse(input int b);
      @(posedge ref_clk);
      ev[b] <= 1'b1;
      @(posedge ref_clk);
      ev[b] <= 1'b0;
   endtask
   task automatic tPowerUp();
      cyc(4);
      check("busReady", {7'h00, busReady}, 8'h00);
      oscRun <= 1'b1;
      rdChk("ctrl", E, 8'h00);
      rdChk("flags", F, 8'h70);
      check("pins", {5'h00, aOe, bOe, sOe}, 8'h00);
      check("pin data", {5'h00, aN, bN, sN}, 8'h00);
      wr(4'h3, 8'hFF);
      rdChk("unmapped", 4'h3, 8'h00);
   endtask
   task automatic tMonitor();
      pulse(5);
      cyc(2);
      check("sampling", {7'h00, sampleEn}, 8'h00);
      wr(F, 8'h00);
      wr(F, 8'hFF);
      rdChk("flags", F, 8'h00);
      rdChk("flags", F, 8'h00);
      // let the open window run out: ticks stand a second apart in the device
      cyc(LEN);
      pulse(5);
      cyc(2);
      check("sampling", {7'h00, sampleEn}, 8'h01);
      cyc(LEN);
      check("sampling", {7'h00, sampleEn}, 8'h00);
      supplyBelow <= 1'b1;
      pulse(5);
      cyc(LEN + 2);
      rdChk("flags", F, 8'h40);
      supplyBelow <= 1'b0;
      pulse(5);
      cyc(2);
      check("sampling", {7'h00, sampleEn}, 8'h00);
      wr(F, 8'h00);
   endtask
   task automatic tOscHalt();
      oscRun <= 1'b0;
      cyc(6);
      oscRun <= 1'b1;
      cyc(4);
      rdChk("flags", F, 8'h20);
      wr(F, 8'h00);
      rdChk("flags", F, 8'h00);
   endtask
   task automatic tAlarms();
      wr(E, 8'h00);
      wr(E, 8'hC0);
      timeNow <= {3'h4, 8'h10, 8'h30};
      cyc(4);
      check("pins A B", {6'h00, aOe, bOe}, 8'h02);
      timeNow <= {3'h2, 8'h10, 8'h30};
      cyc(4);
      check("pins A B", {6'h00, aOe, bOe}, 8'h03);
      check("single pin", {5'h00, oneA, oneB, oneOe}, 8'h01);
      rdChk("flags", F, 8'h03);
      wr(F, 8'hFE);
      cyc(1);
      check("pins A B", {6'h00, aOe, bOe}, 8'h01);
      rdChk("flags", F, 8'h02);
      rdChk("ctrl", E, 8'hC0);
      timeNow <= {3'h2, 8'h10, 8'h31};
      cyc(2);
      timeNow <= {3'h2, 8'h10, 8'h30};
      cyc(4);
      check("pin A", {7'h00, aOe}, 8'h01);
      wr(E, 8'h00);
      cyc(1);
      check("pins A B", {6'h00, aOe, bOe}, 8'h00);
      check("single pin", {5'h00, oneA, oneB, oneOe}, 8'h00);
      wr(F, 8'h00);
      wr(E, 8'h40);
      cyc(4);
      check("pins A B", {6'h00, aOe, bOe}, 8'h00);
      timeNow <= {3'h2, 8'h10, 8'h31};
      cyc(2);
      timeNow <= {3'h2, 8'h10, 8'h30};
      cyc(4);
      check("pins A B", {6'h00, aOe, bOe}, 8'h02);
      wr(E, 8'h00);
      wr(F, 8'h00);
   endtask
   task automatic tPeriodic();
      wr(E, 8'h01);
      cyc(1);
      check("pin A", {7'h00, aOe}, 8'h01);
      check("single pin", {7'h00, oneOe}, 8'h01);
      // code 2 follows wave2Hz (bit 0), code 3 wave1Hz (bit 1)
      for (int c = 2; c < 4; c++)
      begin
         wr(E, 8'(c));
         ev[c - 2] <= 1'b0;
         cyc(3);
         check("pin A", {7'h00, aOe}, 8'h01);
         ev[c - 2] <= 1'b1;
         cyc(3);
         check("pin A", {7'h00, aOe}, 8'h00);
      end
      for (int k = 4; k < 8; k++)
      begin
         wr(E, 8'(k));
         pulse(9 - k);
         cyc(3);
         check("pin A", {7'h00, aOe}, 8'h01);
         rdChk("flags", F, 8'h04);
         wr(F, 8'hFB);
         cyc(1);
         check("pin A", {7'h00, aOe}, 8'h00);
      end
      wr(E, 8'h00);
      cyc(1);
      check("pin A", {7'h00, aOe}, 8'h00);
   endtask
   initial
   begin
      resetn = 1'b0;
      oscRun = 1'b0;
      supplyBelow = 1'b0;
      ev = 6'h03;
      timeNow = {3'h2, 8'h09, 8'h00};
      wkTime = {3'h2, 8'h10, 8'h30};
      dyTime = {3'h5, 8'h10, 8'h30};
      nFail = 0;
      numChecks = 0;
      cycles = 0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      tPowerUp();
      tMonitor();
      tOscHalt();
      tAlarms();
      tPeriodic();
      closeOut();
   end
endmodule // test_rtc_monitor_and_alarm_interrupts
`default_nettype wire
